// ---- lpcs_buf_mem.sv ----
// character buffer: one write port, one registered read port
`timescale 1ns/1ps
module lpcs_buf_mem #(
    parameter int DEPTH = 132,
    parameter int AW = 8,
    parameter int DW = 7
) (
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_q;

    // write and registered read; no reset, contents are rewritten per line
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i && (int'(waddr_i) < DEPTH)) begin
                mem[waddr_i] <= wdata_i;
            end
            if (int'(raddr_i) < DEPTH) begin
                rdata_q <= mem[raddr_i];
            end
        end
    end

    assign rdata_o = rdata_q;
endmodule // lpcs_buf_mem

// ---- lpcs_defines.svh ----
// offsets, field positions, reset values and timing figures of the printer sequencer
`ifndef LPCS_DEFINES_SVH
`define LPCS_DEFINES_SVH

// register byte offsets on the apb bus
`define LPCS_OFF_CTRL 8'h00
`define LPCS_OFF_STAT 8'h04
`define LPCS_OFF_LINES 8'h08

// control register fields and reset value
`define LPCS_CTRL_LPI8 0
`define LPCS_CTRL_CHAR62 1
`define LPCS_CTRL_SLOW 2
`define LPCS_CTRL_RST 3'h0

// character and word layout
`define LPCS_STOP_CODE 6'h3F
`define LPCS_POSITIONS 132
`define LPCS_WORDS 27
`define LPCS_CHARS_PER_WORD 5

// clock rate in mhz, so that cycles = microseconds * rate
`define LPCS_CLK_MHZ 40

// times in microseconds, as specified
`define LPCS_T_FUNC_US 4
`define LPCS_T_RESP_US 1
`define LPCS_T_GUARD_US 30000
`define LPCS_T_SPACE1_US 11500
`define LPCS_T_SPACE2_6_US 16500
`define LPCS_T_SPACE2_8_US 17200
`define LPCS_T_ADD_6_US 5060
`define LPCS_T_ADD_8_US 5700
`define LPCS_T_CODE_US 595
`define LPCS_T_REV_FAST_US 37500
`define LPCS_T_REV_SLOW_US 75000

`endif

// ---- lpcs_host_model.sv ----
// host channel and print drum model facing the sequencer
`timescale 1ns/1ps
module lpcs_host_model (
    input wire logic clk_i,
    input wire logic arm_i,
    input wire logic [4:0] term_at_i,
    input wire logic out_req_i,
    output logic out_ack_o = 1'b0,
    output logic [29:0] out_data_o = 30'h0,
    output logic term_o = 1'b0,
    output logic drum_code_valid_o = 1'b0,
    output logic [5:0] drum_code_o = 6'h00
);
    logic [4:0] idx_q = 5'h00;
    logic [1:0] wait_q = 2'h0;
    logic [7:0] gap_q = 8'h00;

    // answer each demand a few cycles late; word 1 carries the stop code
    always_ff @(posedge clk_i) begin
        out_ack_o <= 1'b0;
        term_o <= 1'b0;
        out_data_o <= ~out_data_o; // idle bus keeps toggling, never a stale word
        if (!arm_i) begin
            idx_q <= 5'h00;
            wait_q <= 2'h0;
        end else if (out_req_i && !out_ack_o && !term_o) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == 2'h3) begin
                idx_q <= idx_q + 5'h01;
                term_o <= (idx_q == term_at_i);
                out_ack_o <= (idx_q != term_at_i);
                out_data_o <= idx_q[0] ? {12'h000, 6'h3F, 6'h07, 6'h06}
                                       : {6'h05, 6'h04, 6'h03, 6'h02, 6'h01};
            end
        end
    end

    // drum wheel runs free: 63 codes, evenly spaced
    always_ff @(posedge clk_i) begin
        gap_q <= (gap_q == 8'h95) ? 8'h00 : gap_q + 8'h01;
        drum_code_valid_o <= (gap_q == 8'h95);
        if (gap_q == 8'h95) begin
            drum_code_o <= (drum_code_o == 6'h3E) ? 6'h00 : drum_code_o + 6'h01;
        end
    end
endmodule // lpcs_host_model

// ---- lpcs_pkg.sv ----
// types shared by the printer sequencer files
package lpcs_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        LPCS_IDLE = 4'h0,
        LPCS_FDLY = 4'h1,
        LPCS_LREQ = 4'h2,
        LPCS_LWR = 4'h3,
        LPCS_LPAD = 4'h4,
        LPCS_PRINT = 4'h5,
        LPCS_INTW = 4'h6,
        LPCS_INTA = 4'h7,
        LPCS_NXTW = 4'h8,
        LPCS_NXTR = 4'h9
    } lpcs_state_e;

    // function codes on the host channel
    typedef enum logic [1:0] {
        LPCS_FN_SPACE = 2'h0,
        LPCS_FN_PRINT_INT = 2'h1,
        LPCS_FN_PRINT_NOINT = 2'h2,
        LPCS_FN_NONE = 2'h3
    } lpcs_func_e;

    // status word code
    typedef logic [1:0] lpcs_status_t;

endpackage

// ---- lpcs_seq.sv ----
// line printer control sequencer: word loading, line spacing, drum compare/print
// Function
// - spacing starts on function or later-line word
// - no-advance print still waits 11.5 ms
// - spacing time from line count and pitch
// - demand word, take word and strobe, withdraw
// - store each character with print flag
// - load until 27 words or stop code
// - first word demand 4 us after function
// - stop code pads rest non-printing, ends load
// - octal 77 stops only in 62-char setting
// - next line load after print, not before 30 ms
// - abort at later line start ends function
// - other aborts pad buffer and end load
// - print after both spacing and loading done
// - match fires hammer, clears position flag
// - scan with no flag left ends line
// - drum codes 595 us apart, speed selectable
// - interrupt at completion, not before 30 ms
// - after interrupt ack, demand and ready again
// - no-interrupt line end demands next word
// - sync, one scan per code, final scan
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "lpcs_defines.svh"
module lpcs_seq #(
    parameter int T_SPACE1 = `LPCS_T_SPACE1_US * `LPCS_CLK_MHZ,
    parameter int T_SPACE2_6 = `LPCS_T_SPACE2_6_US * `LPCS_CLK_MHZ,
    parameter int T_SPACE2_8 = `LPCS_T_SPACE2_8_US * `LPCS_CLK_MHZ,
    parameter int T_ADD_6 = `LPCS_T_ADD_6_US * `LPCS_CLK_MHZ,
    parameter int T_ADD_8 = `LPCS_T_ADD_8_US * `LPCS_CLK_MHZ,
    parameter int T_GUARD = `LPCS_T_GUARD_US * `LPCS_CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // host channel
    input wire logic func_i,
    input wire logic [1:0] func_code_i,
    input wire logic [5:0] func_lines_i,
    input wire logic term_i,
    output logic out_req_o,
    input wire logic out_ack_i,
    input wire logic [29:0] out_data_i,
    output logic ext_int_o,
    input wire logic ext_int_ack_i,
    output logic [1:0] status_o,
    // printer mechanism
    input wire logic drum_code_valid_i,
    input wire logic [5:0] drum_code_i,
    output logic drum_slow_o,
    output logic spacing_o,
    output logic [5:0] space_lines_o,
    output logic hammer_fire_o,
    output logic [7:0] hammer_col_o
);
    localparam int T_FUNC = `LPCS_T_FUNC_US * `LPCS_CLK_MHZ;
    localparam int T_RESP = `LPCS_T_RESP_US * `LPCS_CLK_MHZ;
    localparam logic [7:0] LAST_POS = 8'(`LPCS_POSITIONS - 1);
    localparam logic [1:0] ST_NORMAL = 2'h1;

    lpcs_pkg::lpcs_state_e st_q, st_d;
    logic [2:0] ctrl_q;
    logic [23:0] spc_cnt_q;
    logic [5:0] lines_q;
    logic [20:0] tmr_q;
    logic [7:0] dly_q;
    logic noint_q;
    logic [29:0] word_q;
    logic [4:0] words_q;
    logic [2:0] chr_q;
    logic [7:0] pos_q;
    logic [5:0] cur_chr;
    logic is_stop;
    logic space_go;
    logic [23:0] space_len;
    logic scan_act_q, rd_vld_q, any_q, line_done;
    logic [7:0] scan_idx_q, rd_pos_q;
    logic [5:0] code_q;
    logic [6:0] rdata;
    logic flag_rd, match;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [6:0] mem_wdata;
    logic [15:0] line_cnt_q;
    logic tmr_done;
    logic acc;

    assign tmr_done = (tmr_q == 21'h0);
    assign cur_chr = word_q[chr_q*6 +: 6];
    assign is_stop = ctrl_q[`LPCS_CTRL_CHAR62] && (cur_chr == `LPCS_STOP_CODE);
    assign flag_rd = rdata[6];
    assign match = rd_vld_q && flag_rd && (rdata[5:0] == code_q);
    assign line_done = rd_vld_q && (rd_pos_q == LAST_POS) && !any_q
        && !(flag_rd && !match);

    // spacing starts on a function or on the first word of a later line
    always_comb begin
        space_go = 1'b0;
        if (st_q == lpcs_pkg::LPCS_IDLE && func_i
            && func_code_i != lpcs_pkg::LPCS_FN_NONE) begin
            space_go = 1'b1;
        end
        if (st_q == lpcs_pkg::LPCS_NXTR && out_ack_i) begin
            space_go = 1'b1;
        end
    end

    // spacing length from the line count and the pitch selector
    always_comb begin
        logic [5:0] n;
        n = (st_q == lpcs_pkg::LPCS_IDLE) ? func_lines_i : lines_q;
        if (n <= 6'h01) begin
            space_len = 24'(T_SPACE1);
        end else if (ctrl_q[`LPCS_CTRL_LPI8]) begin
            space_len = 24'(T_SPACE2_8 + int'(n - 6'h02) * T_ADD_8);
        end else begin
            space_len = 24'(T_SPACE2_6 + int'(n - 6'h02) * T_ADD_6);
        end
    end

    // spacing timer, runs alongside loading
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            spc_cnt_q <= 24'h0;
        end else if (ce_i) begin
            if (space_go) begin
                spc_cnt_q <= space_len;
            end else if (spc_cnt_q != 24'h0) begin
                spc_cnt_q <= spc_cnt_q - 24'h1;
            end
        end
    end

    // 30 ms guard timer, restarted at each function receipt
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tmr_q <= 21'h0;
        end else if (ce_i) begin
            if (st_q == lpcs_pkg::LPCS_IDLE && func_i) begin
                tmr_q <= 21'(T_GUARD);
            end else if (!tmr_done) begin
                tmr_q <= tmr_q - 21'h1;
            end
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            lpcs_pkg::LPCS_IDLE: begin
                if (func_i && (func_code_i == lpcs_pkg::LPCS_FN_PRINT_INT
                    || func_code_i == lpcs_pkg::LPCS_FN_PRINT_NOINT)) begin
                    st_d = lpcs_pkg::LPCS_FDLY;
                end
            end
            lpcs_pkg::LPCS_FDLY: begin
                if (dly_q == 8'h0) begin
                    st_d = lpcs_pkg::LPCS_LREQ;
                end
            end
            lpcs_pkg::LPCS_LREQ: begin
                if (term_i) begin
                    st_d = lpcs_pkg::LPCS_LPAD;
                end else if (out_ack_i) begin
                    st_d = lpcs_pkg::LPCS_LWR;
                end
            end
            lpcs_pkg::LPCS_LWR: begin
                if (is_stop) begin
                    st_d = lpcs_pkg::LPCS_LPAD;
                end else if (chr_q == 3'(`LPCS_CHARS_PER_WORD - 1)) begin
                    if (words_q == 5'(`LPCS_WORDS)) begin
                        st_d = lpcs_pkg::LPCS_PRINT;
                    end else begin
                        st_d = lpcs_pkg::LPCS_LREQ;
                    end
                end
            end
            lpcs_pkg::LPCS_LPAD: begin
                if (pos_q >= LAST_POS) begin
                    st_d = lpcs_pkg::LPCS_PRINT;
                end
            end
            lpcs_pkg::LPCS_PRINT: begin
                if (line_done) begin
                    st_d = noint_q ? lpcs_pkg::LPCS_NXTW : lpcs_pkg::LPCS_INTW;
                end
            end
            lpcs_pkg::LPCS_INTW: begin
                if (tmr_done) begin
                    st_d = lpcs_pkg::LPCS_INTA;
                end
            end
            lpcs_pkg::LPCS_INTA: begin
                if (ext_int_ack_i) begin
                    st_d = lpcs_pkg::LPCS_IDLE;
                end
            end
            lpcs_pkg::LPCS_NXTW: begin
                if (dly_q == 8'h0 && tmr_done) begin
                    st_d = lpcs_pkg::LPCS_NXTR;
                end
            end
            lpcs_pkg::LPCS_NXTR: begin
                if (term_i) begin
                    st_d = lpcs_pkg::LPCS_IDLE;
                end else if (out_ack_i) begin
                    st_d = lpcs_pkg::LPCS_LWR;
                end
            end
            default: st_d = lpcs_pkg::LPCS_IDLE;
        endcase
    end

    // state, demand and interrupt registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= lpcs_pkg::LPCS_IDLE;
            out_req_o <= 1'b1;
            ext_int_o <= 1'b0;
        end else if (ce_i) begin
            st_q <= st_d;
            out_req_o <= (st_d == lpcs_pkg::LPCS_IDLE) || (st_d == lpcs_pkg::LPCS_LREQ)
                || (st_d == lpcs_pkg::LPCS_NXTR);
            ext_int_o <= (st_d == lpcs_pkg::LPCS_INTA);
        end
    end

    // short delays: 4 us after a function, 1 us after a no-interrupt line
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dly_q <= 8'h0;
        end else if (ce_i) begin
            if (st_q == lpcs_pkg::LPCS_IDLE) begin
                dly_q <= 8'(T_FUNC - 1);
            end else if (st_q == lpcs_pkg::LPCS_PRINT) begin
                dly_q <= 8'(T_RESP - 1);
            end else if (dly_q != 8'h0) begin
                dly_q <= dly_q - 8'h1;
            end
        end
    end

    // function latch, status word and line counter
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            noint_q <= 1'b0;
            lines_q <= 6'h0;
            status_o <= 2'h0;
            line_cnt_q <= 16'h0;
        end else if (ce_i) begin
            if (st_q == lpcs_pkg::LPCS_IDLE && func_i) begin
                noint_q <= (func_code_i == lpcs_pkg::LPCS_FN_PRINT_NOINT);
                lines_q <= func_lines_i;
            end
            if (st_q == lpcs_pkg::LPCS_PRINT && line_done) begin
                status_o <= ST_NORMAL;
                line_cnt_q <= line_cnt_q + 16'h1;
            end
        end
    end

    // word capture, character and position counters during loading
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            word_q <= 30'h0;
            words_q <= 5'h0;
            chr_q <= 3'h0;
            pos_q <= 8'h0;
        end else if (ce_i) begin
            if (st_q == lpcs_pkg::LPCS_FDLY || st_q == lpcs_pkg::LPCS_NXTW) begin
                words_q <= 5'h0;
                pos_q <= 8'h0;
            end else if ((st_q == lpcs_pkg::LPCS_LREQ || st_q == lpcs_pkg::LPCS_NXTR)
                && out_ack_i && !term_i) begin
                word_q <= out_data_i;
                words_q <= words_q + 5'h1;
                chr_q <= 3'h0;
            end else if (st_q == lpcs_pkg::LPCS_LWR && !is_stop) begin
                chr_q <= chr_q + 3'h1;
                if (pos_q <= LAST_POS) begin
                    pos_q <= pos_q + 8'h1;
                end
            end else if (st_q == lpcs_pkg::LPCS_LPAD) begin
                pos_q <= pos_q + 8'h1;
            end
        end
    end

    // drum scan: one buffer position per cycle on each drum code
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scan_act_q <= 1'b0;
            scan_idx_q <= 8'h0;
            rd_vld_q <= 1'b0;
            rd_pos_q <= 8'h0;
            any_q <= 1'b0;
            code_q <= 6'h0;
        end else if (ce_i) begin
            rd_vld_q <= scan_act_q;
            rd_pos_q <= scan_idx_q;
            // printing waits for spacing; first code seen is the drum sync
            if (st_q == lpcs_pkg::LPCS_PRINT && !scan_act_q && !rd_vld_q
                && drum_code_valid_i && spc_cnt_q == 24'h0) begin
                scan_act_q <= 1'b1;
                scan_idx_q <= 8'h0;
                code_q <= drum_code_i;
                any_q <= 1'b0;
            end else if (scan_act_q) begin
                scan_idx_q <= scan_idx_q + 8'h1;
                scan_act_q <= (scan_idx_q != LAST_POS);
            end
            if (rd_vld_q && flag_rd && !match) begin
                any_q <= 1'b1;
            end
        end
    end

    // buffer write port: loading, padding, or flag clear after a match
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = pos_q;
        mem_wdata = 7'h0;
        if (st_q == lpcs_pkg::LPCS_LWR && !is_stop) begin
            mem_we = 1'b1;
            mem_wdata = {1'b1, cur_chr};
        end else if (st_q == lpcs_pkg::LPCS_LPAD || (st_q == lpcs_pkg::LPCS_LWR && is_stop)) begin
            mem_we = 1'b1;
            mem_wdata = 7'h0;
        end else if (match) begin
            mem_we = 1'b1;
            mem_waddr = rd_pos_q;
            mem_wdata = {1'b0, rdata[5:0]};
        end
    end

    lpcs_buf_mem #(
        .DEPTH(`LPCS_POSITIONS),
        .AW(8),
        .DW(7)
    ) u_buf (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(scan_idx_q),
        .rdata_o(rdata)
    );

    // hammer and mechanism outputs, registered
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hammer_fire_o <= 1'b0;
            hammer_col_o <= 8'h0;
            spacing_o <= 1'b0;
            space_lines_o <= 6'h0;
            drum_slow_o <= 1'b0;
        end else if (ce_i) begin
            hammer_fire_o <= match;
            hammer_col_o <= match ? rd_pos_q : hammer_col_o;
            spacing_o <= space_go || (spc_cnt_q > 24'h1);
            space_lines_o <= space_go ? ((st_q == lpcs_pkg::LPCS_IDLE) ? func_lines_i
                : lines_q) : space_lines_o;
            drum_slow_o <= ctrl_q[`LPCS_CTRL_SLOW];
        end
    end

    // apb slave: answer one cycle into the access phase
    assign acc = psel_i && penable_i && !pready_o;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_q <= `LPCS_CTRL_RST;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else if (ce_i) begin
            pready_o <= acc;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
            // write commits at the edge where the master sees pready, not earlier
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `LPCS_OFF_CTRL) begin
                ctrl_q <= pwdata_i[2:0];
            end
            if (acc) begin
                unique case (paddr_i)
                    `LPCS_OFF_CTRL: prdata_o <= {29'h0, ctrl_q};
                    `LPCS_OFF_STAT: prdata_o <= {24'h0, spc_cnt_q != 24'h0, tmr_done,
                        status_o, st_q};
                    `LPCS_OFF_LINES: prdata_o <= {16'h0, line_cnt_q};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end

    // checks
    sequence s_word_taken;
        st_q == lpcs_pkg::LPCS_LREQ && out_ack_i && !term_i;
    endsequence
    sequence s_req_dropped;
        ##1 !out_req_o;
    endsequence
    a_req_drop_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        s_word_taken |-> s_req_dropped)
        else $error("demand not withdrawn after word");
    a_first_req_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        $rose(st_q == lpcs_pkg::LPCS_FDLY) |-> !out_req_o [*8])
        else $error("first demand too early");
    a_print_after_space: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hammer_fire_o |-> spc_cnt_q == 24'h0)
        else $error("hammer fired while spacing");
    a_stop_pad_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == lpcs_pkg::LPCS_LPAD |-> mem_we && !mem_wdata[6])
        else $error("pad entry printable");
    a_stop_char62: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        is_stop |-> ctrl_q[`LPCS_CTRL_CHAR62] && cur_chr == 6'h3F)
        else $error("stop code without 62-char setting");
    a_load_word_cap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        words_q <= 5'h1B)
        else $error("more than 27 words loaded");
    a_int_guard: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(ext_int_o) |-> tmr_done && status_o == ST_NORMAL)
        else $error("interrupt before guard time");
    a_next_guard: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st_q == lpcs_pkg::LPCS_NXTR |-> tmr_done)
        else $error("next line demand before guard time");
    a_abort_line: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        st_q == lpcs_pkg::LPCS_NXTR && term_i |=> st_q == lpcs_pkg::LPCS_IDLE)
        else $error("abort did not end function");
    a_hammer_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i || !ce_i)
        match |-> mem_we && !mem_wdata[6] && mem_waddr == rd_pos_q ##1 hammer_fire_o)
        else $error("match without hammer and clear");
endmodule // lpcs_seq

// ---- lpcs_seq_fix_note.sv ----
// holds no logic; the sequencer and its buffer live in their own units

// ---- lpcs_seq_tb_top.sv ----
// self-checking bench for the printer sequencer
`timescale 1ns/1ps
module lpcs_seq_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, col;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, func = 1'b0, ack, term, ext_int, ext_ack = 1'b0, arm = 1'b0;
    logic [1:0] fcode = 2'h3, status;
    logic [5:0] flines = 6'h00, dcode, slines;
    logic [4:0] term_at = 5'h1F;
    logic [29:0] odata;
    logic oreq, dcv, slow, spacing, fire, ce = 1'b1;
    int mismatches = 0, num_checks = 0, cyc = 0, fires = 0, t0 = 0, n = 0, f0 = 0;
    int csum = 0, c0 = 0;
    // short timings so that a run stays small
    localparam int TB_SP1 = 200, TB_S26 = 300, TB_S28 = 320, TB_A6 = 100, TB_A8 = 110;
    localparam int TB_GUARD = 2000;
    int sp_l[3] = '{0, 2, 3}, sp_c[3] = '{2, 2, 3};
    int sp_x[3] = '{TB_SP1, TB_S26, TB_S28 + TB_A8};

    always #12.5 clk = ~clk;

    // bookkeeping of time and hammer activity
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fire === 1'b1) begin
            fires <= fires + 1;
            csum <= csum + int'(col); // column sum is blind to drum phase
        end
    end

    lpcs_seq #(.T_SPACE1(TB_SP1), .T_SPACE2_6(TB_S26), .T_SPACE2_8(TB_S28), .T_ADD_6(TB_A6),
        .T_ADD_8(TB_A8), .T_GUARD(TB_GUARD)) dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .func_i(func), .func_code_i(fcode), .func_lines_i(flines), .term_i(term),
        .out_req_o(oreq), .out_ack_i(ack), .out_data_i(odata), .ext_int_o(ext_int),
        .ext_int_ack_i(ext_ack), .status_o(status), .drum_code_valid_i(dcv),
        .drum_code_i(dcode), .drum_slow_o(slow), .spacing_o(spacing),
        .space_lines_o(slines), .hammer_fire_o(fire), .hammer_col_o(col));

    lpcs_host_model host (.clk_i(clk), .arm_i(arm), .term_at_i(term_at), .out_req_i(oreq),
        .out_ack_o(ack), .out_data_o(odata), .term_o(term), .drum_code_valid_o(dcv),
        .drum_code_o(dcode));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("unexpected t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send_func(input logic [1:0] code, input logic [5:0] lines);
        for (n = 0; n < 5000 && oreq !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        func <= 1'b1;
        fcode <= code;
        flines <= lines;
        t0 = cyc;
        f0 = fires;
        c0 = csum;
        @(posedge clk);
        func <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 60k cycles
    initial begin
        #1500000;
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clk);
        chk({oreq, ext_int, spacing, fire}, 32'h8);
        rst_n <= 1'b1;
        apb(1'b0, 8'h10, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h00, 32'h6);
        apb(1'b0, 8'h00, 32'h0);
        chk(r, 32'h6);
        chk({31'h0, slow}, 32'h1);
        // spacing lengths for every pitch and a no-advance count
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 8'h00, 32'(sp_c[k]));
            send_func(2'h0, 6'(sp_l[k]));
            for (n = 0; n < 20 && spacing !== 1'b1; n++) @(posedge clk);
            chk_rng(n, 0, 4);
            chk(slines, 6'(sp_l[k]));
            if (k == 1) begin
                // frozen enable holds the count, so the span left after it is unchanged
                ce <= 1'b0;
                repeat (50) @(posedge clk);
                ce <= 1'b1;
            end
            for (n = 0; n < 1000 && spacing === 1'b1; n++) @(posedge clk);
            chk_rng(n, sp_x[k] - 3, sp_x[k] + 3);
        end
        apb(1'b1, 8'h00, 32'h2);
        // interrupting print: terminate in place of the second word
        send_func(2'h1, 6'h00);
        @(posedge clk); // demand is still high in the step of the taking edge
        for (n = 0; n < 300 && oreq !== 1'b1; n++) @(posedge clk);
        chk_rng(cyc - t0, 159, 164);
        term_at <= 5'h01;
        arm <= 1'b1;
        for (n = 0; n < 20000 && ext_int !== 1'b1; n++) @(posedge clk);
        chk_rng(cyc - t0, TB_GUARD, 20000);
        chk(status, 2'h1);
        chk(fires - f0, 5);
        chk(csum - c0, 10);
        ext_ack <= 1'b1;
        arm <= 1'b0;
        @(posedge clk);
        ext_ack <= 1'b0;
        repeat (2) @(posedge clk);
        chk({oreq, ext_int}, 2'h2);
        // no-interrupt print, stop code, terminate in place of the next line's first word
        send_func(2'h2, 6'h00);
        @(posedge clk);
        term_at <= 5'h02;
        arm <= 1'b1;
        for (n = 0; n < 30000 && term !== 1'b1; n++) @(posedge clk);
        chk_rng(cyc - t0, TB_GUARD, 30000);
        arm <= 1'b0; // no stray answers to the ready-for-function demand
        repeat (200) @(posedge clk);
        chk(fires - f0, 7);
        chk(csum - c0, 21);
        chk({oreq, ext_int}, 2'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk(r, 32'h2);
        wrap_up();
    end
endmodule // lpcs_seq_tb_top
